/* File: common/chan_bus_if.sv */
// Bundle between the host port and one channel's register file.
// Assumes a single clock; write is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
interface chan_bus_if;
  import host_port_pkg::*;
  logic [ADDR_W-1:0] addr;   // Register select
  logic [DATA_W-1:0] wdata;  // Write byte
  logic              wr;     // Write pulse
  logic [DATA_W-1:0] rdata;  // Read byte
  logic              irq;    // Interrupt request
  logic              tx_n;   // Transmitter ready, low active
  logic              txd;    // Serial out

  modport port (output addr, wdata, wr, input rdata, irq, tx_n, txd);
  modport chan (input addr, wdata, wr, output rdata, irq, tx_n, txd);
endinterface
`default_nettype wire

/* File: common/host_port_pkg.sv */
// Constants and types shared by the dual channel host bus port.
// Assumes one clock domain; host pins arrive synchronous to clk.
`default_nettype none
package host_port_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;

  // ----------------------------------------------------------------
  // Register offsets and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_TX_HOLDING = 3'h0;
  localparam logic [2:0] OFS_IRQ_ENABLE = 3'h1;
  localparam logic [2:0] OFS_ALT_FUNC = 3'h2;
  localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
  localparam int ALT_BOTH_BIT = 0;
  localparam int MODEM_IR_BIT = 6;
  localparam int IRQ_TX_EMPTY_BIT = 1;
  localparam int LSR_THR_EMPTY_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h08;

  // ----------------------------------------------------------------
  // Timing: bit time of the crude shifter, in ns and in clk cycles
  // ----------------------------------------------------------------
  localparam int BIT_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;

  // Access phase of the strobe tracker
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b11
  } access_type;

endpackage
`default_nettype wire

/* File: logic/dual_channel_host_bus_port.sv */
// Top of the dual channel parallel host port with two channels.
// Assumes host pins synchronous to clk; the pad joins data enables.
// What this block does
// RULE1: Read strobe falling edge reads selected register onto the data bus.
// RULE2: Host captures read byte at the read strobe rising edge.
// RULE3: Write strobe falls to start, rising edge latches data into register.
// RULE4: Transfers only while unit select is low, to one channel; with alternate function bit 0 set, writes reach both.
// RULE5: Channel pick low selects channel B, high selects channel A.
// RULE6: Alternate function bit 0 makes a write reach both channels.
// RULE7: Each channel drives its own active-high interrupt request.
// RULE8: Each channel drives an active-low transmitter-ready output.
// RULE9: Modem-control bit 6 clear: standard serial, transmit idles high.
// RULE10: Modem-control bit 6 set: infrared interface, idles low.
// RULE11: Register select is three bits, picking a channel register.
// RULE12: Data bus is eight bits, bidirectional.
// RULE13: Data drivers enabled only while unit select and read strobe low.
`timescale 1ns/1ns
`default_nettype none
module dual_channel_host_bus_port
  import host_port_pkg::*;
(
  input  wire logic              clk,               // System clock
  input  wire logic              resetn,            // Async reset, low
  input  wire logic [ADDR_W-1:0] reg_select,        // Register select
  input  wire logic [DATA_W-1:0] host_data_bus_in,  // Data from host
  output logic      [DATA_W-1:0] host_data_bus_out, // Data to host
  output logic                   host_data_bus_oe,  // High while driving
  input  wire logic              read_strobe_n,     // Read strobe, low
  input  wire logic              write_strobe_n,    // Write strobe, low
  input  wire logic              unit_select_n,     // Unit select, low
  input  wire logic              channel_pick,      // 1 = A, 0 = B
  output logic                   irq_channel_a,     // Interrupt A
  output logic                   irq_channel_b,     // Interrupt B
  output logic                   tx_space_flag_a_n, // TX ready A, low
  output logic                   tx_space_flag_b_n, // TX ready B, low
  output logic                   serial_out_a,      // Serial out A
  output logic                   serial_out_b       // Serial out B
);

  // ----------------------------------------------------------------
  // Strobe tracking
  // ----------------------------------------------------------------
  access_type        phase, next_phase;
  logic              latched_a, next_latched_a;
  logic [ADDR_W-1:0] wr_addr, next_wr_addr;
  logic [DATA_W-1:0] wr_data, next_wr_data;
  logic [DATA_W-1:0] rd_byte, next_rd_byte;
  logic              wr_a, wr_b, both;
  logic [DATA_W-1:0] alternate_function_reg, next_alt;
  logic              pick_a;

  chan_bus_if bus_a ();
  chan_bus_if bus_b ();

  assign pick_a = channel_pick; // RULE5

  // Phase machine; read and write start on falling strobe
  always_comb begin
    next_phase = phase;
    next_latched_a = latched_a;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_rd_byte = rd_byte;
    wr_a = 1'b0;
    wr_b = 1'b0;
    next_alt = alternate_function_reg;
    both = alternate_function_reg[ALT_BOTH_BIT];
    case (phase)
      ACC_IDLE: begin
        if (!unit_select_n && !read_strobe_n) begin // RULE4
          next_phase = ACC_READ;                    // RULE1
          next_latched_a = pick_a;
          next_rd_byte = pick_a ? bus_a.rdata : bus_b.rdata; // RULE11
        end else if (!unit_select_n && !write_strobe_n) begin
          next_phase = ACC_WRITE;                   // RULE3
          next_latched_a = pick_a;
        end
      end
      ACC_READ: begin
        // Byte stays until the host lets the strobe rise
        if (read_strobe_n || unit_select_n) begin
          next_phase = ACC_IDLE; // RULE2
        end
      end
      ACC_WRITE: begin
        next_wr_addr = reg_select;
        next_wr_data = host_data_bus_in; // RULE12
        if (write_strobe_n || unit_select_n) begin
          next_phase = ACC_IDLE;
          // Rising edge commits the byte taken while the strobe was low
          wr_a = latched_a || both; // RULE6
          wr_b = !latched_a || both;
          if (wr_addr == OFS_ALT_FUNC) begin
            next_alt = wr_data;
          end
        end
      end
      default: next_phase = ACC_IDLE;
    endcase
  end

  // Strobe state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= ACC_IDLE;
      latched_a <= 1'b0;
      wr_addr <= 3'h0;
      wr_data <= 8'h00;
      rd_byte <= 8'h00;
      alternate_function_reg <= REG_RESET;
    end else begin
      phase <= next_phase;
      latched_a <= next_latched_a;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      rd_byte <= next_rd_byte;
      alternate_function_reg <= next_alt;
    end
  end

  // ----------------------------------------------------------------
  // Channel bundles
  // ----------------------------------------------------------------
  // Reads use the live select, writes the latched one
  assign bus_a.addr = (phase == ACC_WRITE) ? wr_addr : reg_select;
  assign bus_b.addr = (phase == ACC_WRITE) ? wr_addr : reg_select;
  assign bus_a.wdata = wr_data;
  assign bus_b.wdata = wr_data;
  assign bus_a.wr = wr_a; // RULE3
  assign bus_b.wr = wr_b;

  uart_channel_regs chan_a (
    .clk    (clk),
    .resetn (resetn),
    .bus    (bus_a)
  );

  uart_channel_regs chan_b (
    .clk    (clk),
    .resetn (resetn),
    .bus    (bus_b)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data driven only during a selected read
  assign host_data_bus_out = rd_byte;
  assign host_data_bus_oe = (phase == ACC_READ) && !unit_select_n
                            && !read_strobe_n; // RULE13

  // Per-channel status pins
  assign irq_channel_a = bus_a.irq;     // RULE7
  assign irq_channel_b = bus_b.irq;
  assign tx_space_flag_a_n = bus_a.tx_n; // RULE8
  assign tx_space_flag_b_n = bus_b.tx_n;
  assign serial_out_a = bus_a.txd;       // RULE9
  assign serial_out_b = bus_b.txd;       // RULE10

endmodule
`default_nettype wire

/* File: logic/uart_channel_regs.sv */
// One channel: register file, holding register and serial shifter.
// Assumes writes arrive as one-cycle pulses on the channel bundle.
`timescale 1ns/1ns
`default_nettype none
module uart_channel_regs
  import host_port_pkg::*;
(
  input  wire logic clk,       // System clock
  input  wire logic resetn,    // Async reset, low active
  chan_bus_if.chan  bus        // Bundle from host port
);

  // ----------------------------------------------------------------
  // Registers and shifter
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [DATA_W-1:0] next_regs [NUM_REGS];
  logic              holding_full, next_holding_full;
  logic [9:0]        shift, next_shift;
  logic [3:0]        bits_left, next_bits_left;
  logic [7:0]        bit_cnt, next_bit_cnt;
  logic              ir_mode;
  logic              tx_empty;

  assign ir_mode = regs[OFS_MODEM_CTRL][MODEM_IR_BIT];
  assign tx_empty = !holding_full;

  // Next state of registers and shifter
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_holding_full = holding_full;
    next_shift = shift;
    next_bits_left = bits_left;
    next_bit_cnt = bit_cnt;
    if (bus.wr) begin
      next_regs[bus.addr] = bus.wdata;
      if (bus.addr == OFS_TX_HOLDING) begin
        next_holding_full = 1'b1;
      end
    end
    if (bits_left != 4'h0) begin
      if (bit_cnt == 8'(BIT_CYCLES - 1)) begin
        next_bit_cnt = 8'h00;
        next_shift = {1'b1, shift[9:1]};
        next_bits_left = bits_left - 4'h1;
      end else begin
        next_bit_cnt = bit_cnt + 8'h01;
      end
    end else if (holding_full && !bus.wr) begin
      next_shift = {1'b1, regs[OFS_TX_HOLDING], 1'b0};
      next_bits_left = 4'ha;
      next_bit_cnt = 8'h00;
      next_holding_full = 1'b0;
    end
  end

  // Register update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= (i == OFS_MODEM_CTRL) ? MODEM_CTRL_RESET : REG_RESET;
      end
      holding_full <= 1'b0;
      shift <= 10'h3ff;
      bits_left <= 4'h0;
      bit_cnt <= 8'h00;
    end else begin
      regs <= next_regs;
      holding_full <= next_holding_full;
      shift <= next_shift;
      bits_left <= next_bits_left;
      bit_cnt <= next_bit_cnt;
    end
  end

  // Read mux; status register shows holding register state
  always_comb begin
    bus.rdata = regs[bus.addr];
    if (bus.addr == OFS_LINE_STATUS) begin
      bus.rdata = 8'h00;
      bus.rdata[LSR_THR_EMPTY_BIT] = tx_empty;
    end
  end

  // Channel outputs; idle level follows the interface mode
  assign bus.irq = regs[OFS_IRQ_ENABLE][IRQ_TX_EMPTY_BIT] & tx_empty; // RULE7
  assign bus.tx_n = holding_full;                                     // RULE8
  // Standard idles high, infrared encoder idles low
  assign bus.txd = ir_mode ? (bits_left != 4'h0 && !shift[0])  // RULE10
                           : (bits_left == 4'h0 || shift[0]);  // RULE9

endmodule
`default_nettype wire

/* File: tb/host_model.sv */
// Host processor model driving the parallel register bus.
// Assumes the device samples its pins on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input  wire logic              clk,  // Clock
  input  wire logic [DATA_W-1:0] dout, // Device byte
  input  wire logic              oe,   // Device drives bus
  output var  logic [ADDR_W-1:0] a,    // Register select
  output logic      [DATA_W-1:0] din,  // Bus as seen by device
  output var  logic              rd_n, // Read strobe
  output var  logic              wr_n, // Write strobe
  output var  logic              cs_n, // Unit select
  output var  logic              pick  // Channel pick
);
  logic [DATA_W-1:0] hd;
  // Shared data wire, inverted last byte once released
  assign din = oe ? dout : hd;
  initial {cs_n, rd_n, wr_n, pick, a, hd} = {4'hf, 3'h0, 8'h00};
  // Write cycle; cs high makes it an ignored access
  task automatic wr(input logic cs, input logic ch, input logic [2:0] ad,
                    input logic [7:0] d);
    @(negedge clk);
    {cs_n, pick, a, hd} = {cs, ch, ad, d};
    wr_n = 1'b0;
    repeat (3) @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    {cs_n, hd} = {1'b1, ~d};
    repeat (2) @(negedge clk);
  endtask
  // Read cycle, bounded wait for the device to drive
  task automatic rd(input logic ch, input logic [2:0] ad,
                    output logic [7:0] q);
    int n;
    @(negedge clk);
    {cs_n, rd_n, pick, a} = {2'b00, ch, ad};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (oe !== 1'b1 && n < 20);
    // Hold the strobe across one more rising edge after the byte first stands
    @(negedge clk);
    q = (oe === 1'b1) ? dout : 8'hxx;
    {cs_n, rd_n} = 2'b11;
    repeat (2) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/host_port_properties.sv */
// Checker for the dual channel host bus port, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module host_port_properties
  import host_port_pkg::*;
(
  input  wire logic              clk,               // Clock
  input  wire logic              resetn,            // Reset, low
  input  wire logic              read_strobe_n,     // Read strobe
  input  wire logic              write_strobe_n,    // Write strobe
  input  wire logic              unit_select_n,     // Unit select
  input  wire logic [DATA_W-1:0] host_data_bus_out, // Read byte
  input  wire logic              host_data_bus_oe,  // Bus enable
  input  wire logic              irq_channel_a,     // Interrupt A
  input  wire logic              irq_channel_b,     // Interrupt B
  input  wire logic              tx_space_flag_a_n, // TX ready A
  input  wire logic              tx_space_flag_b_n, // TX ready B
  input  wire logic              serial_out_a,      // Serial A
  input  wire logic              serial_out_b       // Serial B
);
  // ----------------------------------------------------------------
  // Bus and pin properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_oe_gate;
    host_data_bus_oe |-> !unit_select_n && !read_strobe_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("bus driven idle");
  property p_oe_rise;
    $fell(read_strobe_n) && !unit_select_n && write_strobe_n
      |=> host_data_bus_oe;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("no read data");
  property p_oe_hold;
    host_data_bus_oe ##1 (!read_strobe_n && !unit_select_n)
      |-> host_data_bus_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("read cut short");
  property p_data_stable;
    host_data_bus_oe ##1 host_data_bus_oe |-> $stable(host_data_bus_out);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("byte moved");
  property p_irq_a;
    irq_channel_a |-> !tx_space_flag_a_n;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a without cause");
  property p_irq_b;
    irq_channel_b |-> !tx_space_flag_b_n;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b without cause");
  property p_reset_line;
    disable iff (1'b0) !resetn |-> serial_out_a && serial_out_b;
  endproperty
  a_reset_line: assert property (p_reset_line) else $error("line low");
  property p_reset_flags;
    disable iff (1'b0) !resetn |-> !tx_space_flag_a_n && !tx_space_flag_b_n
      && !irq_channel_a && !irq_channel_b;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags set");
endmodule

bind dual_channel_host_bus_port host_port_properties props (
  .clk, .resetn, .read_strobe_n, .write_strobe_n, .unit_select_n,
  .host_data_bus_out, .host_data_bus_oe, .irq_channel_a, .irq_channel_b,
  .tx_space_flag_a_n, .tx_space_flag_b_n, .serial_out_a, .serial_out_b
);
`default_nettype wire

/* File: tb/tb_dual_channel_host_bus_port.sv */
// Self-checking bench for the dual channel host bus port.
// Assumes host_model drives the bus at the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module tb_dual_channel_host_bus_port;
  import host_port_pkg::*;
  logic       clk = 1'b0;
  logic       resetn = 1'b1;
  logic [2:0] rsel;
  logic [7:0] din, dout, q;
  logic       oe, rd_n, wr_n, cs_n, pick, ia, ib, fa, fb, sa, sb;
  int         failures = 0;
  int         compares = 0;
  dual_channel_host_bus_port dut (.clk(clk), .resetn(resetn),
    .reg_select(rsel), .host_data_bus_in(din), .host_data_bus_out(dout),
    .host_data_bus_oe(oe), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .unit_select_n(cs_n), .channel_pick(pick), .irq_channel_a(ia),
    .irq_channel_b(ib), .tx_space_flag_a_n(fa), .tx_space_flag_b_n(fb),
    .serial_out_a(sa), .serial_out_b(sb));
  host_model host (.clk(clk), .dout(dout), .oe(oe), .a(rsel), .din(din),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .pick(pick));
  // ----------------------------------------------------------------
  // Clock, watchdog, checks
  // ----------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    failures++;
    test_done();
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk("oe", 8'h00, {7'h0, oe});
    chk("pins", 8'h0c, {4'h0, sb, sa, fb, fa});
    chk("irq", 8'h00, {6'h0, ib, ia});
    $display("reset test done");
  endtask
  task t_route;
    host.wr(1'b0, 1'b1, 3'h3, 8'h5a);
    host.wr(1'b0, 1'b0, 3'h3, 8'ha5);
    host.wr(1'b1, 1'b1, 3'h3, 8'hff);
    host.rd(1'b1, 3'h3, q);
    chk("reg a", 8'h5a, q);
    host.rd(1'b0, 3'h3, q);
    chk("reg b", 8'ha5, q);
    $display("routing test done");
  endtask
  task t_both;
    host.wr(1'b0, 1'b1, OFS_ALT_FUNC, 8'h01);
    host.wr(1'b0, 1'b0, 3'h7, 8'h3c);
    host.rd(1'b1, 3'h7, q);
    chk("both a", 8'h3c, q);
    host.wr(1'b0, 1'b0, OFS_ALT_FUNC, 8'h00);
    host.wr(1'b0, 1'b0, 3'h7, 8'hc3);
    host.rd(1'b1, 3'h7, q);
    chk("single a", 8'h3c, q);
    host.rd(1'b0, 3'h7, q);
    chk("single b", 8'hc3, q);
    $display("global write test done");
  endtask
  task t_tx;
    int         n;
    logic [7:0] b;
    host.wr(1'b0, 1'b1, OFS_IRQ_ENABLE, 8'h02);
    chk("irq on", 8'h01, {6'h0, ib, ia});
    host.wr(1'b0, 1'b1, OFS_TX_HOLDING, 8'h55);
    n = 0;
    while (sa !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("start bit", 8'h00, {7'h0, sa});
    // Sample each data bit shortly after it starts, low bit first
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(negedge clk);
      b[i] = sa;
    end
    chk("frame byte", 8'h55, b);
    repeat (3 * BIT_CYCLES) @(negedge clk);
    chk("after frame", 8'h06, {5'h0, sa, ia, fa});
    host.rd(1'b1, OFS_LINE_STATUS, q);
    chk("status", 8'h20, q);
    $display("transmit test done");
  endtask
  task t_ir;
    host.wr(1'b0, 1'b0, OFS_MODEM_CTRL, 8'h48);
    repeat (4) @(negedge clk);
    chk("line idle", 8'h01, {6'h0, sb, sa});
    host.wr(1'b0, 1'b0, OFS_IRQ_ENABLE, 8'h02);
    chk("irq b", 8'h03, {6'h0, ib, ia});
    $display("infrared test done");
  endtask
  // Reset in mid-run: lines back to standard idle, registers back to reset values
  task t_rst;
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset line", 8'h03, {6'h0, sb, sa});
    resetn = 1'b1;
    host.rd(1'b0, OFS_MODEM_CTRL, q);
    chk("modem reset", MODEM_CTRL_RESET, q);
    chk("reset irq", 8'h00, {6'h0, ib, ia});
    $display("mid-run reset test done");
  endtask
  initial begin
    // Drop reset after time zero so the async branch surely fires
    #1;
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_route();
    t_both();
    t_tx();
    t_ir();
    t_rst();
    test_done();
  end
endmodule
`default_nettype wire
